/* File: logic/vfiu_pend.sv */
// Eight pending flags, set by events and cleared by strobes
// Assumes: set and clear come from logic on the same clock
`timescale 1ns/1ps
module vfiu_pend (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Set and clear strobes
    input wire logic [7:0] i_set,
    input wire logic [7:0] i_clr,
    // Flags
    output logic [7:0] o_pend
);

    typedef struct packed {
        logic [7:0] pend;
    } vfiu_pend_state_t;

    vfiu_pend_state_t s_q;
    vfiu_pend_state_t s_d;
    logic [7:0] nxt;

    // ------------------------------------------------------------
    // Per flag update, a set beats a clear
    // ------------------------------------------------------------
    for (genvar b = 0; b < 8; b++) begin : g_flag
        assign nxt[b] = i_set[b] | (s_q.pend[b] & ~i_clr[b]);
    end

    always_comb begin
        s_d.pend = nxt;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_pend = s_q.pend;

endmodule : vfiu_pend

/* File: logic/vfiu_pkg.sv */
// Constants, register map and state type of the vectored and fast interrupt unit
// Assumes: included first; all users refer to names through vfiu_pkg::
package vfiu_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] A_PTR_HI = 8'hda;
    localparam logic [7:0] A_PTR_LO = 8'hdb;
    localparam logic [7:0] A_STATUS = 8'hdc;
    localparam logic [7:0] A_MASK = 8'hdd;
    localparam logic [7:0] A_MODE = 8'hde;
    localparam logic [7:0] A_PRIO = 8'hff;
    localparam logic [7:0] A_SWP = 8'hd0;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int MODE_GEN = 0;
    localparam int MODE_FEN = 1;
    localparam int MODE_FLS_LO = 2;
    localparam int MODE_FLS_HI = 4;
    localparam logic [7:0] MODE_WMASK = 8'h9f;
    localparam logic [7:0] FLG_FAST = 8'h02;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int PRIO_GA = 7;
    localparam int PRIO_GB = 4;
    localparam int PRIO_GC = 1;
    localparam int NHW = 4;

    // ------------------------------------------------------------
    // Level groups and vectors
    // ------------------------------------------------------------
    localparam logic [7:0] GRP_A = 8'h03;
    localparam logic [7:0] GRP_B = 8'h1c;
    localparam logic [7:0] GRP_C = 8'he0;
    localparam logic [7:0] VEC_HW_BASE = 8'h00;
    localparam logic [7:0] VEC_SW_BASE = 8'h10;

    // ------------------------------------------------------------
    // Entry timing in clock cycles
    // ------------------------------------------------------------
    localparam int ENTRY_CYC = 22;
    localparam int FAST_CYC = 6;
    localparam logic [4:0] ENTRY_END = 5'(ENTRY_CYC - 1);
    localparam logic [4:0] FAST_END = 5'(FAST_CYC - 1);
    localparam logic [4:0] CNT_START = 5'h01;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_PUSH_PCL, ST_PUSH_PCH, ST_PUSH_FLG, ST_FETCH_HI,
        ST_FETCH_LO, ST_TAKE_LO, ST_JUMP, ST_FAST, ST_POP_PCH,
        ST_POP_PCL, ST_RET_END
    } vfiu_state_t;

endpackage : vfiu_pkg

/* File: logic/vfiu_prio.sv */
// Level priority resolver: picks the winning level among masked requests
// Assumes: purely combinational, fed from registers on the same clock
`timescale 1ns/1ps
module vfiu_prio (
    // Requests and priority setting
    input wire logic [7:0] i_req,
    input wire logic [7:0] i_prio,
    // Result
    output logic o_any,
    output logic [2:0] o_lvl
);

    logic [5:0] ord;
    logic found;
    logic [7:0] m;

    // ------------------------------------------------------------
    // Group order, first group in the top two bits
    // ------------------------------------------------------------
    function automatic logic [5:0] grp_order(input logic [2:0] sel);
        case (sel)
            3'h1: grp_order = {2'h1, 2'h2, 2'h0};
            3'h2: grp_order = {2'h0, 2'h1, 2'h2};
            3'h3: grp_order = {2'h1, 2'h0, 2'h2};
            3'h4: grp_order = {2'h2, 2'h0, 2'h1};
            3'h5: grp_order = {2'h2, 2'h1, 2'h0};
            3'h6: grp_order = {2'h0, 2'h2, 2'h1};
            default: grp_order = {2'h0, 2'h1, 2'h2};
        endcase
    endfunction : grp_order

    function automatic logic [7:0] grp_mask(input logic [1:0] g);
        case (g)
            2'h0: grp_mask = vfiu_pkg::GRP_A;
            2'h1: grp_mask = vfiu_pkg::GRP_B;
            default: grp_mask = vfiu_pkg::GRP_C;
        endcase
    endfunction : grp_mask

    function automatic logic [2:0] lowest(input logic [7:0] v);
        lowest = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                lowest = 3'(i);
            end
        end
    endfunction : lowest

    // ------------------------------------------------------------
    // Resolve
    // ------------------------------------------------------------
    always_comb begin
        ord = grp_order({i_prio[vfiu_pkg::PRIO_GA], i_prio[vfiu_pkg::PRIO_GB],
                         i_prio[vfiu_pkg::PRIO_GC]});
        o_any = |i_req;
        o_lvl = 3'h0;
        found = 1'b0;
        m = 8'h00;
        for (int g = 0; g < 3; g++) begin
            m = i_req & grp_mask(ord[5 - 2 * g -: 2]);
            if (!found && (|m)) begin
                found = 1'b1;
                o_lvl = lowest(m);
            end
        end
    end

endmodule : vfiu_prio

/* File: logic/vfiu_top.sv */
// Vectored and fast interrupt unit of an 8-bit CPU core
// Assumes: CPU sequencer and peripherals share i_clk; stack and ROM data
// are valid in the cycle in which the pop or read strobe is high
`timescale 1ns/1ps
module vfiu_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Interrupt sources
    input wire logic [3:0] i_hw_evt,
    input wire logic [7:0] i_sw_evt,
    input wire logic [7:0] i_src_en,
    // CPU sequencer
    input wire logic i_instr_end,
    input wire logic i_interrupt_return_instr,
    input wire logic [15:0] i_pc,
    input wire logic [7:0] i_flags,
    input wire logic [7:0] i_stack_rdata,
    input wire logic [7:0] i_rom_data,
    output logic o_ack,
    output logic [2:0] o_ack_level,
    output logic o_stack_push,
    output logic o_stack_pop,
    output logic [7:0] o_stack_wdata,
    output logic o_rom_rd,
    output logic [7:0] o_rom_addr,
    output logic o_pc_load,
    output logic [15:0] o_pc_new,
    output logic o_flags_load,
    output logic [7:0] o_flags_new,
    // Status
    output logic o_fast_active,
    output logic o_gie
);

    typedef struct packed {
        vfiu_pkg::vfiu_state_t st;
        logic [4:0] cnt;
        logic [2:0] lvl;
        logic [7:0] ptr_hi;
        logic [7:0] ptr_lo;
        logic [7:0] mask;
        logic [7:0] prio;
        logic [7:0] mode;
        logic [7:0] shadow;
        logic fast;
        logic ack;
        logic push;
        logic pop;
        logic [7:0] wdata;
        logic rom_rd;
        logic [7:0] rom_addr;
        logic pc_load;
        logic [15:0] pc_new;
        logic flg_load;
        logic [7:0] flg_new;
        logic [7:0] rdata;
    } vfiu_top_state_t;

    vfiu_top_state_t s_q;
    vfiu_top_state_t s_d;

    logic [7:0] hw_pend;
    logic [7:0] sw_pend;
    logic [7:0] hw_clr;
    logic [7:0] sw_clr;
    logic [7:0] req_lvl;
    logic [7:0] cand;
    logic any;
    logic [2:0] win;
    logic win_hw;
    logic accept;
    logic go_fast;
    logic [7:0] vec;

    // ------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------
    vfiu_pend u_hw_pend (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_set({4'h0, i_hw_evt}),
        .i_clr(hw_clr),
        .o_pend(hw_pend)
    );

    vfiu_pend u_sw_pend (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_set(i_sw_evt),
        .i_clr(sw_clr),
        .o_pend(sw_pend)
    );

    // ------------------------------------------------------------
    // Request gating and selection
    // ------------------------------------------------------------
    assign req_lvl = ({4'h0, hw_pend[vfiu_pkg::NHW-1:0]} | sw_pend) & i_src_en;
    assign cand = req_lvl & s_q.mask;

    vfiu_prio u_prio (
        .i_req(cand),
        .i_prio(s_q.prio),
        .o_any(any),
        .o_lvl(win)
    );

    // Hardware source has the lower vector, so it wins its level
    assign win_hw = hw_pend[win];
    assign vec = (win_hw ? vfiu_pkg::VEC_HW_BASE : vfiu_pkg::VEC_SW_BASE)
                 + {4'h0, win, 1'b0};
    assign accept = (s_q.st == vfiu_pkg::ST_IDLE) && !i_interrupt_return_instr && i_instr_end
                    && s_q.mode[vfiu_pkg::MODE_GEN] && !s_q.fast && any;
    assign go_fast = s_q.mode[vfiu_pkg::MODE_FEN]
                     && (win == s_q.mode[vfiu_pkg::MODE_FLS_HI:vfiu_pkg::MODE_FLS_LO]);
    assign hw_clr = (accept && win_hw) ? (8'h01 << win) : 8'h00;
    assign sw_clr = (i_reg_wr && i_reg_addr == vfiu_pkg::A_SWP) ? ~i_reg_wdata : 8'h00;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.push = 1'b0;
        s_d.pop = 1'b0;
        s_d.rom_rd = 1'b0;
        s_d.pc_load = 1'b0;
        s_d.flg_load = 1'b0;
        // Register writes
        if (i_reg_wr) begin
            case (i_reg_addr)
                vfiu_pkg::A_PTR_HI: s_d.ptr_hi = i_reg_wdata;
                vfiu_pkg::A_PTR_LO: s_d.ptr_lo = i_reg_wdata;
                vfiu_pkg::A_MASK: s_d.mask = i_reg_wdata;
                vfiu_pkg::A_PRIO: s_d.prio = i_reg_wdata;
                vfiu_pkg::A_MODE: s_d.mode = i_reg_wdata & vfiu_pkg::MODE_WMASK;
                default: s_d.mode = s_q.mode;
            endcase
        end
        // Register reads
        if (i_reg_rd) begin
            case (i_reg_addr)
                vfiu_pkg::A_PTR_HI: s_d.rdata = s_q.ptr_hi;
                vfiu_pkg::A_PTR_LO: s_d.rdata = s_q.ptr_lo;
                vfiu_pkg::A_STATUS: s_d.rdata = req_lvl;
                vfiu_pkg::A_MASK: s_d.rdata = s_q.mask;
                vfiu_pkg::A_PRIO: s_d.rdata = s_q.prio;
                vfiu_pkg::A_MODE: s_d.rdata = s_q.mode;
                vfiu_pkg::A_SWP: s_d.rdata = sw_pend;
                default: s_d.rdata = vfiu_pkg::REG_RST;
            endcase
        end
        // Entry and return sequencer
        case (s_q.st)
            vfiu_pkg::ST_IDLE: begin
                if (i_interrupt_return_instr && s_q.fast) begin
                    s_d.pc_load = 1'b1;
                    s_d.pc_new = {s_q.ptr_hi, s_q.ptr_lo};
                    {s_d.ptr_hi, s_d.ptr_lo} = i_pc;
                    s_d.flg_load = 1'b1;
                    s_d.flg_new = s_q.shadow & ~vfiu_pkg::FLG_FAST;
                    s_d.fast = 1'b0;
                    s_d.mode[vfiu_pkg::MODE_GEN] = 1'b1;
                end else if (i_interrupt_return_instr) begin
                    s_d.pop = 1'b1;
                    s_d.st = vfiu_pkg::ST_POP_PCH;
                end else if (accept) begin
                    s_d.ack = 1'b1;
                    s_d.lvl = win;
                    s_d.mode[vfiu_pkg::MODE_GEN] = 1'b0;
                    s_d.cnt = vfiu_pkg::CNT_START;
                    s_d.rom_addr = vec;
                    s_d.st = go_fast ? vfiu_pkg::ST_FAST : vfiu_pkg::ST_PUSH_PCL;
                end
            end
            vfiu_pkg::ST_PUSH_PCL: begin
                s_d.push = 1'b1;
                s_d.wdata = i_pc[7:0];
                s_d.cnt = s_q.cnt + 5'h01;
                s_d.st = vfiu_pkg::ST_PUSH_PCH;
            end
            vfiu_pkg::ST_PUSH_PCH: begin
                s_d.push = 1'b1;
                s_d.wdata = i_pc[15:8];
                s_d.cnt = s_q.cnt + 5'h01;
                s_d.st = vfiu_pkg::ST_PUSH_FLG;
            end
            vfiu_pkg::ST_PUSH_FLG: begin
                s_d.push = 1'b1;
                s_d.wdata = i_flags;
                s_d.cnt = s_q.cnt + 5'h01;
                s_d.st = vfiu_pkg::ST_FETCH_HI;
            end
            vfiu_pkg::ST_FETCH_HI: begin
                s_d.rom_rd = 1'b1;
                s_d.cnt = s_q.cnt + 5'h01;
                s_d.st = vfiu_pkg::ST_FETCH_LO;
            end
            vfiu_pkg::ST_FETCH_LO: begin
                s_d.pc_new[15:8] = i_rom_data;
                s_d.rom_rd = 1'b1;
                s_d.rom_addr = s_q.rom_addr + 8'h01;
                s_d.cnt = s_q.cnt + 5'h01;
                s_d.st = vfiu_pkg::ST_TAKE_LO;
            end
            vfiu_pkg::ST_TAKE_LO: begin
                s_d.pc_new[7:0] = i_rom_data;
                s_d.cnt = s_q.cnt + 5'h01;
                s_d.st = vfiu_pkg::ST_JUMP;
            end
            vfiu_pkg::ST_JUMP: begin
                if (s_q.cnt == vfiu_pkg::ENTRY_END) begin
                    s_d.pc_load = 1'b1;
                    s_d.st = vfiu_pkg::ST_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt + 5'h01;
                end
            end
            vfiu_pkg::ST_FAST: begin
                if (s_q.cnt == vfiu_pkg::FAST_END) begin
                    s_d.pc_load = 1'b1;
                    s_d.pc_new = {s_q.ptr_hi, s_q.ptr_lo};
                    {s_d.ptr_hi, s_d.ptr_lo} = i_pc;
                    s_d.shadow = i_flags;
                    s_d.flg_load = 1'b1;
                    s_d.flg_new = i_flags | vfiu_pkg::FLG_FAST;
                    s_d.fast = 1'b1;
                    s_d.st = vfiu_pkg::ST_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt + 5'h01;
                end
            end
            vfiu_pkg::ST_POP_PCH: begin
                s_d.flg_new = i_stack_rdata;
                s_d.pop = 1'b1;
                s_d.st = vfiu_pkg::ST_POP_PCL;
            end
            vfiu_pkg::ST_POP_PCL: begin
                s_d.pc_new[15:8] = i_stack_rdata;
                s_d.pop = 1'b1;
                s_d.st = vfiu_pkg::ST_RET_END;
            end
            vfiu_pkg::ST_RET_END: begin
                s_d.pc_new[7:0] = i_stack_rdata;
                s_d.pc_load = 1'b1;
                s_d.flg_load = 1'b1;
                s_d.mode[vfiu_pkg::MODE_GEN] = 1'b1;
                s_d.st = vfiu_pkg::ST_IDLE;
            end
            default: s_d.st = vfiu_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_reg_rdata = s_q.rdata;
    assign o_ack = s_q.ack;
    assign o_ack_level = s_q.lvl;
    assign o_stack_push = s_q.push;
    assign o_stack_pop = s_q.pop;
    assign o_stack_wdata = s_q.wdata;
    assign o_rom_rd = s_q.rom_rd;
    assign o_rom_addr = s_q.rom_addr;
    assign o_pc_load = s_q.pc_load;
    assign o_pc_new = s_q.pc_new;
    assign o_flags_load = s_q.flg_load;
    assign o_flags_new = s_q.flg_new;
    assign o_fast_active = s_q.fast;
    assign o_gie = s_q.mode[vfiu_pkg::MODE_GEN];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    sequence s_push3;
        o_stack_push [*3];
    endsequence

    sequence s_fetch2;
        o_rom_rd [*2];
    endsequence

    property p_entry_order;
        (o_ack && s_q.st == vfiu_pkg::ST_PUSH_PCL) |=> s_push3 ##1 s_fetch2;
    endproperty
    a_entry_order: assert property (p_entry_order)
        else $error("entry pushes and vector reads out of order");

    property p_entry_len;
        (o_ack && s_q.st == vfiu_pkg::ST_PUSH_PCL) |-> ##21 o_pc_load;
    endproperty
    a_entry_len: assert property (p_entry_len)
        else $error("normal entry did not load PC after 22 cycles");

    property p_fast_len;
        (o_ack && s_q.st == vfiu_pkg::ST_FAST) |-> ##5 (o_pc_load && o_fast_active && o_flags_load);
    endproperty
    a_fast_len: assert property (p_fast_len)
        else $error("fast entry did not complete after 6 cycles");

    property p_ack_cause;
        o_ack |-> ($past(i_instr_end) && $past(o_gie) && !$past(o_fast_active));
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("acknowledge without instruction end or global enable");

    property p_ack_gie;
        o_ack |-> !o_gie;
    endproperty
    a_ack_gie: assert property (p_ack_gie)
        else $error("global enable not cleared on entry");

    property p_fis_block;
        o_fast_active |=> !o_ack;
    endproperty
    a_fis_block: assert property (p_fis_block)
        else $error("request accepted while fast service active");

    property p_interrupt_return_instr_norm;
        (s_q.st == vfiu_pkg::ST_IDLE && i_interrupt_return_instr && !s_q.fast)
            |-> ##4 (o_pc_load && o_flags_load && o_gie);
    endproperty
    a_interrupt_return_instr_norm: assert property (p_interrupt_return_instr_norm)
        else $error("normal return did not restore PC, flags and enable");

    property p_fast_ret;
        (s_q.st == vfiu_pkg::ST_IDLE && i_interrupt_return_instr && s_q.fast)
            |=> (o_pc_load && o_flags_load && !o_fast_active && o_gie);
    endproperty
    a_fast_ret: assert property (p_fast_ret)
        else $error("fast return did not swap back and clear fast flag");

    property p_sw_setwin;
        i_sw_evt[5] |=> sw_pend[5];
    endproperty
    a_sw_setwin: assert property (p_sw_setwin)
        else $error("software pending event lost against a clear");

endmodule : vfiu_top

/* File: testbench/test_vectored_fast_interrupt_unit.sv */
// Self-checking bench of the vectored and fast interrupt unit
// Assumes: design files and the CPU side model are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module test_vectored_fast_interrupt_unit;
    logic i_clk, i_arst_n, i_reg_wr, i_reg_rd, i_instr_end, i_interrupt_return_instr;
    logic [7:0] i_reg_addr, i_reg_wdata, i_sw_evt, i_src_en, i_flags;
    logic [3:0] i_hw_evt;
    logic [15:0] i_pc;
    logic [7:0] o_reg_rdata, i_stack_rdata, i_rom_data, o_stack_wdata, o_rom_addr, o_flags_new;
    logic o_ack, o_stack_push, o_stack_pop, o_rom_rd, o_pc_load, o_flags_load, o_fast_active, o_gie;
    logic [2:0] o_ack_level;
    logic [15:0] o_pc_new;
    int err_count = 0;
    int num_checks = 0;
    vfiu_top uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_hw_evt(i_hw_evt), .i_sw_evt(i_sw_evt),
        .i_src_en(i_src_en), .i_instr_end(i_instr_end), .i_interrupt_return_instr(i_interrupt_return_instr), .i_pc(i_pc),
        .i_flags(i_flags), .i_stack_rdata(i_stack_rdata), .i_rom_data(i_rom_data),
        .o_ack(o_ack), .o_ack_level(o_ack_level), .o_stack_push(o_stack_push),
        .o_stack_pop(o_stack_pop), .o_stack_wdata(o_stack_wdata), .o_rom_rd(o_rom_rd),
        .o_rom_addr(o_rom_addr), .o_pc_load(o_pc_load), .o_pc_new(o_pc_new),
        .o_flags_load(o_flags_load), .o_flags_new(o_flags_new),
        .o_fast_active(o_fast_active), .o_gie(o_gie));
    vfiu_cpu_model cpu (.i_clk(i_clk), .i_push(o_stack_push), .i_pop(o_stack_pop),
        .i_wdata(o_stack_wdata), .o_stack_rdata(i_stack_rdata), .i_rom_rd(o_rom_rd),
        .i_rom_addr(o_rom_addr), .o_rom_data(i_rom_data));
    // ------------------------------------------------------------
    // Bus cycles and sequences
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        @(posedge i_clk);
        #1 `CHK(o_reg_rdata, e)
    endtask : rd
    task automatic ev(input logic [3:0] hw, input logic [7:0] sw);
        @(posedge i_clk);
        i_hw_evt <= hw;
        i_sw_evt <= sw;
        @(posedge i_clk);
        i_hw_evt <= 4'h0;
        i_sw_evt <= 8'h00;
    endtask : ev
    task automatic quiet();
        @(posedge i_clk);
        i_instr_end <= 1'b1;
        repeat (3) begin
            @(posedge i_clk);
            i_instr_end <= 1'b0;
            #1 `CHK(o_ack, 1'b0)
        end
    endtask : quiet
    task automatic go(input logic ret, input int e, input logic [15:0] pc, input logic [2:0] l);
        int n;
        @(posedge i_clk);
        if (ret) i_interrupt_return_instr <= 1'b1;
        else i_instr_end <= 1'b1;
        for (n = 1; n < 40; n++) begin
            @(posedge i_clk);
            i_interrupt_return_instr <= 1'b0;
            i_instr_end <= 1'b0;
            #1;
            if (!ret && n == 1) begin
                `CHK(o_ack, 1'b1)
                `CHK(o_ack_level, l)
            end
            if (o_pc_load === 1'b1) break;
        end
        `CHK(n, e)
        `CHK(o_pc_new, pc)
    endtask : go
    task automatic summarize();
        if (err_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_poll();
        rd(vfiu_pkg::A_STATUS, 8'h00);
        rd(vfiu_pkg::A_MODE, 8'h00);
        ev(4'h0, 8'h20);
        rd(vfiu_pkg::A_STATUS, 8'h20);
        quiet();
        wr(vfiu_pkg::A_SWP, 8'hdf);
        wr(vfiu_pkg::A_STATUS, 8'hff);
        rd(vfiu_pkg::A_STATUS, 8'h00);
        wr(vfiu_pkg::A_MODE, 8'h01);
        ev(4'h0, 8'h20);
        quiet();
        wr(vfiu_pkg::A_SWP, 8'h00);
    endtask : t_poll
    task automatic t_vector();
        wr(vfiu_pkg::A_MASK, 8'hff);
        ev(4'h2, 8'h00);
        rd(vfiu_pkg::A_STATUS, 8'h02);
        go(1'b0, 22, 16'h4243, 3'd1);
        `CHK(o_gie, 1'b0)
        `CHK({cpu.stk[0], cpu.stk[1], cpu.stk[2]}, 24'h563481)
        rd(vfiu_pkg::A_STATUS, 8'h00);
        rd(vfiu_pkg::A_MASK, 8'hff);
        wr(vfiu_pkg::A_MASK, 8'h01);
        wr(vfiu_pkg::A_MASK, 8'hff);
        go(1'b1, 4, 16'h3456, 3'd0);
        `CHK({o_flags_new, o_gie}, 9'h103)
    endtask : t_vector
    task automatic t_fast();
        wr(vfiu_pkg::A_PTR_HI, 8'h12);
        wr(vfiu_pkg::A_PTR_LO, 8'h34);
        rd(vfiu_pkg::A_PTR_HI, 8'h12);
        wr(vfiu_pkg::A_MODE, 8'h0f);
        ev(4'h8, 8'h00);
        go(1'b0, 6, 16'h1234, 3'd3);
        `CHK({o_flags_new, o_fast_active}, 9'h107)
        wr(vfiu_pkg::A_MODE, 8'h0f);
        ev(4'h1, 8'h00);
        quiet();
        go(1'b1, 1, 16'h3456, 3'd0);
        `CHK({o_flags_new, o_fast_active, o_gie}, 10'h205)
        wr(vfiu_pkg::A_PTR_HI, 8'h12);
        rd(vfiu_pkg::A_PTR_LO, 8'h56);
    endtask : t_fast
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        #100000;
        err_count++;
        summarize();
    end
    initial begin
        {i_arst_n, i_reg_wr, i_reg_rd, i_instr_end, i_interrupt_return_instr} = 5'h00;
        {i_reg_addr, i_reg_wdata, i_sw_evt, i_hw_evt} = 28'h0;
        i_src_en = 8'hff;
        i_pc = 16'h3456;
        i_flags = 8'h81;
        repeat (8) @(posedge i_clk);
        i_arst_n <= 1'b1;
        t_poll();
        t_vector();
        t_fast();
        summarize();
    end
endmodule : test_vectored_fast_interrupt_unit

/* File: testbench/vfiu_cpu_model.sv */
// CPU side model: system stack and vector ROM answering the interrupt unit
// Assumes: push, pop and ROM read are one-cycle strobes on i_clk
`timescale 1ns/1ps
module vfiu_cpu_model (
    // Clock
    input wire logic i_clk,
    // Stack port
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_stack_rdata,
    // Vector ROM port
    input wire logic i_rom_rd,
    input wire logic [7:0] i_rom_addr,
    output logic [7:0] o_rom_data
);
    // ------------------------------------------------------------
    // Stack and ROM
    // ------------------------------------------------------------
    logic [7:0] stk [0:7];
    logic [2:0] sp = 3'h0;
    logic [7:0] top;
    logic [7:0] rom;
    assign top = stk[sp - 3'h1];
    assign rom = i_rom_addr + 8'h40;
    // Lines not being read show the inverse of the data
    assign o_stack_rdata = i_pop ? top : ~top;
    assign o_rom_data = i_rom_rd ? rom : ~rom;
    always @(posedge i_clk) begin
        if (i_push) begin
            stk[sp] <= i_wdata;
            sp <= sp + 3'h1;
        end else if (i_pop) begin
            sp <= sp - 3'h1;
        end
    end
endmodule : vfiu_cpu_model
